/* fcrc_array_model.sv */
module fcrc_array_model (
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   srst,
   // controller side
   input  wire fcrc_pkg::fcrc_arr_req_t arrReq,
   input  wire logic [17:0]            rdAddr,
   input  wire logic                   failNext,
   output logic [15:0]                 arrRdData,
   output logic                        arrDone,
   output logic                        arrFail
);
   timeunit 1ns;
   timeprecision 1ns;
   import fcrc_pkg::*;

   // ****************************************
   // word store, erased state is all ones
   // ****************************************
   logic [15:0] mem [0:131071];
   int          waitCnt_q;
   logic        slow_q;

   initial begin
      for (int k = 0; k < 131072; k++) begin
         mem[k] = 16'hffff;
      end
   end

   // look-up follows the address in the same cycle
   assign arrRdData = mem[rdAddr[17:1]];

   // alternate a prompt and a slow finish so both waits get exercised
   always @(posedge ref_clk) begin
      arrDone <= 1'b0;
      arrFail <= 1'b0;
      if (srst) begin
         waitCnt_q <= 0;
         slow_q    <= 1'b0;
      end else if (arrReq.stb) begin
         waitCnt_q <= slow_q ? 7 : 1;
         slow_q    <= ~slow_q;
         if (arrReq.kind == OP_PROG) begin
            mem[arrReq.programTargetAddress[17:1]] <=
               arrReq.programWordValue;
         end else begin
            // only the masked blocks go back to erased
            for (int k = 0; k < 131072; k++) begin
               if (arrReq.eraseMask[k[16:14]]) begin
                  mem[k] <= 16'hffff;
               end
            end
         end
      end else if (waitCnt_q == 1) begin
         arrDone   <= 1'b1;
         arrFail   <= failNext; // a failure only when the bench asks
         waitCnt_q <= 0;
      end else if (waitCnt_q > 1) begin
         waitCnt_q <= waitCnt_q - 1;
      end
   end
endmodule

/* fcrc_ctrl.sv */
// Overview of operation
// - three flash modes: processor rewrite, parallel programmer, serial programmer
// - block erase touches exactly one block, others stay intact
// - each block has a lock bit; locked blocks refuse program and erase
// - boot area alterable only in parallel programmer mode
// - boot area is one undivided 8 Kbyte erase unit
// - program and erase start only from command sequences, not plain writes
// - in processor rewrite mode only user blocks may change, unless the parallel strap is also on
// - in rewrite mode ordinary fetches do not return array contents
// - command byte decode: read, id, status, clear, program, erase, lock
// - odd-address command writes and the upper data byte are ignored
// - ready flag is 0 while program or erase runs, else 1
// - mode bit sets only on write 0 then 1; a write 0 clears it
module fcrc_ctrl #(
   parameter logic [15:0] ID_CODE = 16'h1234   // arbitrary value
) (
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   srst,
   // processor access
   input  wire fcrc_pkg::fcrc_cmd_t    cmd,
   output logic                        rdValid,
   output logic [15:0]                 rdData,
   // mode select bit writes
   input  wire logic                   modeWr,
   input  wire logic                   modeWrVal,
   output logic                        rewriteMode,
   // programmer mode straps, asynchronous pins
   input  wire logic                   parPin,
   input  wire logic                   serPin,
   // flash array
   output fcrc_pkg::fcrc_arr_req_t     arrReq,
   input  wire logic [15:0]            arrRdData,
   input  wire logic                   arrDone,
   input  wire logic                   arrFail,
   // status
   output logic                        arrayReadyFlag,
   output logic [7:0]                  statusReadoutByte
);
   import fcrc_pkg::*;

   // ********************************************************
   // state
   // ********************************************************
   localparam fcrc_regs_t RST = '{
      state: ST_IDLE, rdMode: RD_ARRAY, ready: 1'b1, progErr: 1'b0,
      eraseErr: 1'b0, modeArmed: 1'b0, rewriteMode: 1'b0,
      locks: '0, req: '{stb: 1'b0, kind: OP_PROG,
                        programTargetAddress: '0,
                        programWordValue: '0, eraseMask: '0},
      rdData: '0, rdValid: 1'b0, parS1: 1'b0, parS2: 1'b0,
      serS1: 1'b0, serS2: 1'b0};

   fcrc_regs_t            cur;
   fcrc_regs_t            nxt;
   logic                  accepting;
   logic                  cmdTake;
   logic [7:0]            cmdByte;
   logic [BLK_IDX_W-1:0]  blkIdx;
   logic                  tgtOk;
   logic                  bootOk;
   logic                  inRange;
   logic [NUM_BLOCKS-1:0] tgtMask;
   logic [NUM_BLOCKS-1:0] allMask;
   logic [7:0]            statusByte;
   logic                  setProg;
   logic                  setErase;
   logic                  clrStat;

   // ********************************************************
   // next-state logic
   // ********************************************************
   always_comb begin
      nxt = cur;
      nxt.req.stb = 1'b0;
      nxt.rdValid = 1'b0;
      setProg = 1'b0;
      setErase = 1'b0;
      clrStat = 1'b0;
      // pin straps cross into the clock domain first
      nxt.parS1 = parPin;
      nxt.parS2 = cur.parS1;
      nxt.serS1 = serPin;
      nxt.serS2 = cur.serS1;
      // any of the three modes opens the command port
      accepting = cur.rewriteMode | cur.parS2 | cur.serS2;
      // even address and low byte only
      cmdTake = cmd.wr & ~cmd.addr[0] & accepting;
      cmdByte = cmd.data[7:0];
      // block index straight from the high address bits
      blkIdx = cmd.addr[ADDR_W-1 -: BLK_IDX_W];
      inRange = cmd.addr < BOOT_END;
      // boot is one unit and only parallel mode may touch it
      bootOk = (blkIdx != BOOT_IDX) | cur.parS2;
      tgtMask = NUM_BLOCKS'(1) << blkIdx;
      tgtOk = inRange & bootOk & ~cur.locks[blkIdx];
      // erase all skips locked blocks, and boot unless parallel mode
      allMask = ~cur.locks & (cur.parS2 ? '1 : ~(NUM_BLOCKS'(1) << BOOT_IDX));
      statusByte = '0;
      statusByte[SR_READY_BIT] = cur.ready;
      statusByte[SR_ERASE_BIT] = cur.eraseErr;
      statusByte[SR_PROG_BIT] = cur.progErr;

      // mode select bit needs 0 then 1 in succession
      if (modeWr) begin
         if (!modeWrVal) begin
            nxt.rewriteMode = 1'b0;
            nxt.modeArmed = 1'b1;
         end else begin
            nxt.rewriteMode = cur.rewriteMode | cur.modeArmed;
            nxt.modeArmed = 1'b0;
         end
      end

      // read answers; fetches see zeros in rewrite mode
      if (cmd.rd) begin
         nxt.rdValid = 1'b1;
         if (cmd.fetch && cur.rewriteMode) begin
            nxt.rdData = '0;
         end else begin
            unique case (cur.rdMode)
               RD_ARRAY:  nxt.rdData = arrRdData;
               RD_ID:     nxt.rdData = ID_CODE;
               RD_STATUS: nxt.rdData = {8'h00, statusByte};
               RD_LOCK: begin
                  // lock reads as 0 on bit 6 when the block is locked
                  nxt.rdData = '0;
                  nxt.rdData[LOCK_OUT_BIT] = ~cur.locks[blkIdx];
               end
            endcase
         end
      end

      // command sequencer; only decoded sequences reach the array
      unique case (cur.state)
         ST_IDLE: begin
            if (cmdTake) begin
               case (cmdByte)
                  CMD_READ:     nxt.rdMode = RD_ARRAY;
                  CMD_ID:       nxt.rdMode = RD_ID;
                  CMD_STATUS:   nxt.rdMode = RD_STATUS;
                  CMD_LOCKRD:   nxt.rdMode = RD_LOCK;
                  CMD_CLEAR:    clrStat = 1'b1;
                  CMD_PROGRAM:  nxt.state = ST_PROG_WAIT;
                  CMD_ERASE:    nxt.state = ST_ERASE_WAIT;
                  CMD_ERASEALL: nxt.state = ST_ERALL_WAIT;
                  CMD_LOCKPRG:  nxt.state = ST_LOCK_WAIT;
                  default:      nxt.state = ST_IDLE;
               endcase
            end
         end
         ST_PROG_WAIT: begin
            // data write after the program code
            if (cmdTake) begin
               nxt.state = ST_IDLE;
               nxt.rdMode = RD_STATUS;
               if (tgtOk) begin
                  nxt.req.stb = 1'b1;
                  nxt.req.kind = OP_PROG;
                  nxt.req.programTargetAddress =
                     {cmd.addr[ADDR_W-1:1], 1'b0};
                  nxt.req.programWordValue = cmd.data;
                  nxt.req.eraseMask = tgtMask;
                  nxt.ready = 1'b0;
                  nxt.state = ST_BUSY;
               end else begin
                  setProg = 1'b1;
               end
            end
         end
         ST_ERASE_WAIT: begin
            if (cmdTake) begin
               nxt.state = ST_IDLE;
               nxt.rdMode = RD_STATUS;
               if (cmdByte == CMD_CONFIRM && tgtOk) begin
                  nxt.req.stb = 1'b1;
                  nxt.req.kind = OP_ERASE_BLK;
                  nxt.req.eraseMask = tgtMask;
                  nxt.ready = 1'b0;
                  nxt.state = ST_BUSY;
               end else begin
                  setErase = 1'b1;
               end
            end
         end
         ST_ERALL_WAIT: begin
            if (cmdTake) begin
               nxt.state = ST_IDLE;
               nxt.rdMode = RD_STATUS;
               if (cmdByte == CMD_CONFIRM && allMask != '0) begin
                  nxt.req.stb = 1'b1;
                  nxt.req.kind = OP_ERASE_ALL;
                  nxt.req.eraseMask = allMask;
                  nxt.ready = 1'b0;
                  nxt.state = ST_BUSY;
               end else if (cmdByte != CMD_CONFIRM) begin
                  setErase = 1'b1;
               end
            end
         end
         ST_LOCK_WAIT: begin
            if (cmdTake) begin
               nxt.state = ST_IDLE;
               nxt.rdMode = RD_STATUS;
               if (cmdByte == CMD_CONFIRM && inRange && bootOk) begin
                  nxt.locks[blkIdx] = 1'b1;
               end else begin
                  setProg = 1'b1;
               end
            end
         end
         ST_BUSY: begin
            // command writes are ignored until the array finishes; reads and mode bit writes still act
            if (arrDone) begin
               nxt.ready = 1'b1;
               nxt.state = ST_IDLE;
               setProg = arrFail & (cur.req.kind == OP_PROG);
               setErase = arrFail & (cur.req.kind != OP_PROG);
            end
         end
      endcase

      // leaving every mode drops a half-entered sequence
      if (!accepting && cur.state != ST_BUSY) begin
         nxt.state = ST_IDLE;
      end
      // a failure landing with a clear is kept: set wins
      nxt.progErr = (cur.progErr & ~clrStat) | setProg;
      nxt.eraseErr = (cur.eraseErr & ~clrStat) | setErase;
   end

   // ********************************************************
   // registers
   // ********************************************************
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cur <= RST;
      end else begin
         cur <= nxt;
      end
   end

   assign rdValid = cur.rdValid;
   assign rdData = cur.rdData;
   assign rewriteMode = cur.rewriteMode;
   assign arrReq = cur.req;
   assign arrayReadyFlag = cur.ready;
   assign statusReadoutByte = {cur.ready, 1'b0, cur.eraseErr, cur.progErr,
                               4'h0};

   // ********************************************************
   // checks
   // ********************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   a_busy_drop: assert property (arrReq.stb |-> !arrayReadyFlag)
      else $error("ready flag high while an operation starts");
   a_busy_hold: assert property (!arrayReadyFlag && !arrDone
      |=> !arrayReadyFlag)
      else $error("ready flag rose without array done");
   a_odd_ignored: assert property (cmd.wr && cmd.addr[0]
      |=> !arrReq.stb)
      else $error("odd address write started an operation");
   a_lock_guard: assert property (arrReq.stb
      |-> (arrReq.eraseMask & $past(cur.locks)) == '0)
      else $error("operation aimed at a locked block");
   a_boot_guard: assert property (arrReq.stb
      && arrReq.eraseMask[BOOT_IDX] |-> $past(cur.parS2))
      else $error("boot area altered outside parallel mode");
   a_one_block: assert property (arrReq.stb
      && arrReq.kind != OP_ERASE_ALL |-> $onehot(arrReq.eraseMask))
      else $error("single operation touches more than one block");
   a_word_align: assert property (arrReq.stb
      && arrReq.kind == OP_PROG |-> !arrReq.programTargetAddress[0])
      else $error("program address not word aligned");
   a_mode_entry: assert property ($rose(rewriteMode)
      |-> $past(cur.modeArmed) && $past(modeWr) && $past(modeWrVal))
      else $error("rewrite mode set without a 0 then 1 write");
   a_mode_clear: assert property (modeWr && !modeWrVal
      |=> !rewriteMode)
      else $error("write of 0 did not clear rewrite mode");
   a_fetch_blank: assert property (cmd.rd && cmd.fetch
      && rewriteMode |=> rdValid && rdData == '0)
      else $error("fetch returned data in rewrite mode");
   a_accept_only: assert property (arrReq.stb
      |-> $past(cur.rewriteMode || cur.parS2 || cur.serS2))
      else $error("operation started with no flash mode active");

   c_program: cover property (arrReq.stb && arrReq.kind == OP_PROG);
   c_blk_erase: cover property (arrReq.stb && arrReq.kind == OP_ERASE_BLK);
   c_erase_all: cover property (arrReq.stb && arrReq.kind == OP_ERASE_ALL);
   c_mode_on: cover property ($rose(rewriteMode));
endmodule

/* fcrc_pkg.sv */
package fcrc_pkg;

   // ********************************************************
   // array geometry (byte addresses)
   // ********************************************************
   localparam int          ADDR_W      = 18;
   localparam int          BLK_IDX_W   = 3;
   localparam int          NUM_BLOCKS  = 8;   // seven user blocks + boot
   localparam int          BOOT_BYTES  = 8192;
   localparam logic [2:0]  BOOT_IDX    = 3'h7;
   localparam logic [17:0] BOOT_BASE   = 18'h38000;
   localparam logic [17:0] BOOT_END    = 18'h3a000;
   localparam int          WORD_W      = 16;

   // ********************************************************
   // command codes, low byte of a command write
   // ********************************************************
   localparam logic [7:0] CMD_READ     = 8'hff;
   localparam logic [7:0] CMD_ID       = 8'h90;
   localparam logic [7:0] CMD_STATUS   = 8'h70;
   localparam logic [7:0] CMD_CLEAR    = 8'h50;
   localparam logic [7:0] CMD_PROGRAM  = 8'h40;
   localparam logic [7:0] CMD_ERASE    = 8'h20;
   localparam logic [7:0] CMD_ERASEALL = 8'ha7;
   localparam logic [7:0] CMD_LOCKRD   = 8'h71;
   localparam logic [7:0] CMD_LOCKPRG  = 8'h77;
   localparam logic [7:0] CMD_CONFIRM  = 8'hd0;

   // ********************************************************
   // status byte and lock readout bit positions
   // ********************************************************
   localparam int SR_READY_BIT  = 7;
   localparam int SR_ERASE_BIT  = 5;
   localparam int SR_PROG_BIT   = 4;
   localparam int LOCK_OUT_BIT  = 6;

   // ********************************************************
   // types
   // ********************************************************
   typedef enum logic [5:0] {
      ST_IDLE       = 6'h01,
      ST_PROG_WAIT  = 6'h02,
      ST_ERASE_WAIT = 6'h04,
      ST_ERALL_WAIT = 6'h08,
      ST_LOCK_WAIT  = 6'h10,
      ST_BUSY       = 6'h20
   } fcrc_state_t;

   typedef enum logic [3:0] {
      RD_ARRAY  = 4'h1,
      RD_ID     = 4'h2,
      RD_STATUS = 4'h4,
      RD_LOCK   = 4'h8
   } fcrc_rdmode_t;

   typedef enum logic [2:0] {
      OP_PROG      = 3'h1,
      OP_ERASE_BLK = 3'h2,
      OP_ERASE_ALL = 3'h4
   } fcrc_op_t;

   // processor side access
   typedef struct packed {
      logic                wr;
      logic                rd;
      logic                fetch;
      logic [ADDR_W-1:0]   addr;
      logic [WORD_W-1:0]   data;
   } fcrc_cmd_t;

   // request to the flash array
   typedef struct packed {
      logic                  stb;
      fcrc_op_t              kind;
      logic [ADDR_W-1:0]     programTargetAddress;
      logic [WORD_W-1:0]     programWordValue;
      logic [NUM_BLOCKS-1:0] eraseMask;
   } fcrc_arr_req_t;

   // all state of the controller
   typedef struct packed {
      fcrc_state_t           state;
      fcrc_rdmode_t          rdMode;
      logic                  ready;
      logic                  progErr;
      logic                  eraseErr;
      logic                  modeArmed;
      logic                  rewriteMode;
      logic [NUM_BLOCKS-1:0] locks;
      fcrc_arr_req_t         req;
      logic [WORD_W-1:0]     rdData;
      logic                  rdValid;
      logic                  parS1;
      logic                  parS2;
      logic                  serS1;
      logic                  serS2;
   } fcrc_regs_t;

endpackage

/* flash_cpu_rewrite_control_tb.sv */
module flash_cpu_rewrite_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import fcrc_pkg::*;

   typedef struct packed {
      fcrc_op_t kind;
      logic [7:0] mask;
      logic [17:0] a;
      logic [15:0] v;
      logic full;
   } fcrc_exp_t;

   logic          ref_clk;
   logic          srst;
   fcrc_cmd_t     cmd;
   logic          rdValid;
   logic [15:0]   rdData;
   logic          modeWr;
   logic          modeWrVal;
   logic          rewriteMode;
   logic          parPin;
   logic          serPin;
   fcrc_arr_req_t arrReq;
   logic [15:0]   arrRdData;
   logic          arrDone;
   logic          arrFail;
   logic          failNext;
   logic          arrayReadyFlag;
   logic [7:0]    statusReadoutByte;
   logic [15:0]   rdQ [$];
   fcrc_exp_t     reqQ [$];
   int            nFail;
   int            numChecks;
   int            cyc;
   logic [31:0]   seed;
   logic [17:0]   a;
   logic [15:0]   w;

   always #25 ref_clk = ~ref_clk;

   fcrc_ctrl fcrc_ctrl_inst (.ref_clk(ref_clk), .srst(srst), .cmd(cmd),
      .rdValid(rdValid), .rdData(rdData), .modeWr(modeWr),
      .modeWrVal(modeWrVal), .rewriteMode(rewriteMode), .parPin(parPin),
      .serPin(serPin), .arrReq(arrReq), .arrRdData(arrRdData),
      .arrDone(arrDone), .arrFail(arrFail),
      .arrayReadyFlag(arrayReadyFlag),
      .statusReadoutByte(statusReadoutByte));

   fcrc_array_model fcrc_array_model_inst (.ref_clk(ref_clk), .srst(srst),
      .arrReq(arrReq), .rdAddr(cmd.addr), .failNext(failNext),
      .arrRdData(arrRdData), .arrDone(arrDone), .arrFail(arrFail));

   // ****************************************
   // checking and closing
   // ****************************************
   task automatic miss(input string m);
      nFail++;
      $display("Error at %0t: %s", $time, m);
   endtask

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      numChecks++;
      if (got !== exp) begin
         miss($sformatf("got %h expected %h", got, exp));
      end
   endtask

   // erases only fix kind and mask, programs the word too
   task automatic chk_req(input fcrc_exp_t e);
      chk(48'({arrReq.kind, arrReq.eraseMask}),
          48'({e.kind, e.mask}));
      if (e.full) begin
         chk(48'(arrReq.programTargetAddress), 48'(e.a));
         chk(48'(arrReq.programWordValue), 48'(e.v));
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", numChecks, nFail);
      if (nFail == 0 && numChecks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // results are judged mid-cycle, when the registered outputs are settled
   always @(negedge ref_clk) begin
      if (rdValid === 1'b1) begin
         if (rdQ.size() == 0) miss("unexpected read answer");
         else chk(48'(rdData), 48'(rdQ.pop_front()));
      end
      if (arrReq.stb === 1'b1) begin
         if (reqQ.size() == 0) miss("unexpected array start");
         else chk_req(reqQ.pop_front());
      end
   end

   // a hang counts as a mismatch
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         miss("cycle limit reached");
         wrap_up();
      end
   end

   // ****************************************
   // drivers
   // ****************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   task automatic wr(input logic [17:0] ad, input logic [15:0] d);
      @(posedge ref_clk);
      #2;
      cmd.wr = 1'b1;
      cmd.addr = ad;
      cmd.data = d;
      @(posedge ref_clk);
      #2;
      cmd.wr = 1'b0;
   endtask

   task automatic rd(input logic [17:0] ad, input logic f,
                     input logic [15:0] e);
      rdQ.push_back(e);
      @(posedge ref_clk);
      #2;
      cmd.rd = 1'b1;
      cmd.fetch = f;
      cmd.addr = ad;
      @(posedge ref_clk);
      #2;
      cmd.rd = 1'b0;
      cmd.fetch = 1'b0;
   endtask

   task automatic mw(input logic v);
      @(posedge ref_clk);
      #2;
      modeWr = 1'b1;
      modeWrVal = v;
      @(posedge ref_clk);
      #2;
      modeWr = 1'b0;
   endtask

   // the status pins must agree with the status read
   task automatic st(input logic [15:0] e);
      wr(18'h0, 16'h0070);
      rd(18'h0, 1'b0, e);
      chk(48'(statusReadoutByte), 48'(e[7:0]));
   endtask

   // bounded wait for the array to finish
   task automatic wait_ready();
      chk(48'(arrayReadyFlag), 48'h0);
      chk(48'(statusReadoutByte[SR_READY_BIT]), 48'h0);
      for (int k = 0; k < 40 && arrayReadyFlag !== 1'b1; k++) begin
         @(posedge ref_clk);
      end
      #2;
      chk(48'(arrayReadyFlag), 48'h1);
      chk(48'(statusReadoutByte[SR_READY_BIT]), 48'h1);
   endtask

   initial begin
      ref_clk = 1'b0;
      srst = 1'b1;
      cmd = '0;
      modeWr = 1'b0;
      modeWrVal = 1'b0;
      parPin = 1'b0;
      serPin = 1'b0;
      failNext = 1'b0;
      nFail = 0;
      numChecks = 0;
      cyc = 0;
      seed = 32'h18463cd0;
      repeat (16) @(posedge ref_clk);
      #2;
      srst = 1'b0;
      repeat (3) @(posedge ref_clk);
      #2;
      chk(48'(statusReadoutByte), 48'h80);
      chk(48'(arrayReadyFlag), 48'h1);
      wr(18'h0, 16'h0040);
      wr(18'h00100, 16'h1111);
      mw(1'b1);
      chk(48'(rewriteMode), 48'h0);
      mw(1'b0);
      mw(1'b1); // the routine runs from RAM from here on
      chk(48'(rewriteMode), 48'h1);
      wr(18'h00100, 16'h1234);
      rd(18'h00200, 1'b1, 16'h0000);
      // random user-area words, with junk in the ignored upper byte
      for (int i = 0; i < 3; i++) begin
         seed = xs(seed);
         a = {3'(seed[10:8] % 3'd7), seed[14:1], 1'b0};
         w = seed[31:16];
         wr(18'h0, 16'hab40);
         reqQ.push_back('{OP_PROG, 8'h1 << a[17:15], a, w, 1'b1});
         wr(a, w);
         wait_ready();
         st(16'h0080);
         wr(18'h0, 16'h00ff);
         rd(a, 1'b0, w);
      end
      wr(18'h00001, 16'h0020);
      wr(18'h08000, 16'h00d0);
      wr(18'h0, 16'h0020);
      reqQ.push_back('{OP_ERASE_BLK, 8'h02, 18'h0, 16'h0, 1'b0});
      wr(18'h08000, 16'h00d0);
      wait_ready();
      wr(18'h0, 16'h0077);
      wr(18'h10000, 16'h00d0);
      wr(18'h0, 16'h0071);
      rd(18'h10000, 1'b0, 16'h0000);
      rd(18'h08000, 1'b0, 16'h0040);
      wr(18'h0, 16'h0040);
      wr(18'h10010, 16'h5555);
      st(16'h0090);
      wr(18'h0, 16'h0050);
      st(16'h0080);
      wr(18'h0, 16'h0020);
      wr(BOOT_BASE, 16'h00d0);
      st(16'h00a0);
      wr(18'h0, 16'h0050);
      wr(18'h0, 16'h00a7);
      reqQ.push_back('{OP_ERASE_ALL, 8'h7b, 18'h0, 16'h0, 1'b0});
      wr(18'h0, 16'h00d0);
      wait_ready();
      failNext = 1'b1;
      wr(18'h0, 16'h0040);
      reqQ.push_back('{OP_PROG, 8'h01, 18'h00400, 16'h0f0f, 1'b1});
      wr(18'h00400, 16'h0f0f);
      wait_ready();
      failNext = 1'b0;
      st(16'h0090);
      wr(18'h0, 16'h0050);
      wr(18'h0, 16'h0090);
      rd(18'h0, 1'b0, 16'h1234);
      // the boot unit opens only under the parallel strap
      parPin = 1'b1;
      repeat (4) @(posedge ref_clk);
      wr(18'h0, 16'h0020);
      reqQ.push_back('{OP_ERASE_BLK, 8'h80, 18'h0, 16'h0, 1'b0});
      wr(BOOT_BASE, 16'h00d0);
      wait_ready();
      parPin = 1'b0;
      wr(18'h0, 16'h00ff);
      mw(1'b0);
      chk(48'(rewriteMode), 48'h0);
      rd(18'h08000, 1'b1, 16'hffff);
      // the serial strap opens the same port, boot stays shut
      serPin = 1'b1;
      repeat (4) @(posedge ref_clk);
      wr(18'h0, 16'h0040);
      reqQ.push_back('{OP_PROG, 8'h08, 18'h18020, 16'hc3c3, 1'b1});
      wr(18'h18020, 16'hc3c3);
      wait_ready();
      wr(18'h0, 16'h0020);
      wr(BOOT_BASE, 16'h00d0);
      st(16'h00a0);
      wr(18'h0, 16'h0050);
      wr(18'h0, 16'h0020);
      wr(18'h08000, 16'h0021);
      st(16'h00a0);
      wr(18'h0, 16'h00ff);
      rd(18'h18020, 1'b0, 16'hc3c3);
      serPin = 1'b0;
      repeat (4) @(posedge ref_clk);
      mw(1'b0);
      mw(1'b1);
      chk(48'(rewriteMode), 48'h1);
      // a reset in mid-run drops the mode, the error and every lock
      srst = 1'b1;
      repeat (2) @(posedge ref_clk);
      #2;
      srst = 1'b0;
      @(posedge ref_clk);
      #2;
      chk(48'(rewriteMode), 48'h0);
      chk(48'(statusReadoutByte), 48'h80);
      mw(1'b0);
      mw(1'b1);
      wr(18'h0, 16'h0071);
      rd(18'h10000, 1'b0, 16'h0040);
      mw(1'b0);
      repeat (4) @(posedge ref_clk);
      if (rdQ.size() != 0 || reqQ.size() != 0) miss("result never came");
      wrap_up();
   end
endmodule
